/* ipc_top.v */
// interrupt priority configuration: six priority registers on apb
// assumes single pclk domain; software is the only writer
// Notes on behaviour
// RULE1: code 111 gives highest priority 7
// RULE2: code 001 lowest level 1, between linear
// RULE3: code 000 disables the source entirely
// RULE4: reg2 serial rx 14-12, spi event 10-8
// RULE5: reg2 spi fault 6-4, timer three 2-0
// RULE6: reset loads 100; unimplemented bits zero
`include "ipc_consts.vh"
module ipc_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire [2:0]  timer_one_priority,
    output wire [2:0]  outcmp_one_priority,
    output wire [2:0]  incap_one_priority,
    output wire [2:0]  ext_zero_priority,
    output wire [2:0]  timer_two_priority,
    output wire [2:0]  outcmp_two_priority,
    output wire [2:0]  incap_two_priority,
    output wire [2:0]  serial_one_rx_priority,
    output wire [2:0]  spi_one_event_priority,
    output wire [2:0]  spi_one_fault_priority,
    output wire [2:0]  timer_three_priority,
    output wire [2:0]  adc_done_priority,
    output wire [2:0]  serial_one_tx_priority,
    output wire [2:0]  pin_change_priority,
    output wire [2:0]  comparator_priority,
    output wire [2:0]  twowire_master_priority,
    output wire [2:0]  twowire_slave_priority,
    output wire [2:0]  incap_eight_priority,
    output wire [2:0]  incap_seven_priority,
    output wire [2:0]  ext_one_priority,
    output wire [19:0] source_enabled
);

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    // every output port is wired straight from one of these flops
    reg  [31:0] prdata_ff;
    reg         pready_ff;
    reg         pslverr_ff;
    reg  [2:0]  timer_one_priority_ff;
    reg  [2:0]  outcmp_one_priority_ff;
    reg  [2:0]  incap_one_priority_ff;
    reg  [2:0]  ext_zero_priority_ff;
    reg  [2:0]  timer_two_priority_ff;
    reg  [2:0]  outcmp_two_priority_ff;
    reg  [2:0]  incap_two_priority_ff;
    reg  [2:0]  serial_one_rx_priority_ff;
    reg  [2:0]  spi_one_event_priority_ff;
    reg  [2:0]  spi_one_fault_priority_ff;
    reg  [2:0]  timer_three_priority_ff;
    reg  [2:0]  adc_done_priority_ff;
    reg  [2:0]  serial_one_tx_priority_ff;
    reg  [2:0]  pin_change_priority_ff;
    reg  [2:0]  comparator_priority_ff;
    reg  [2:0]  twowire_master_priority_ff;
    reg  [2:0]  twowire_slave_priority_ff;
    reg  [2:0]  incap_eight_priority_ff;
    reg  [2:0]  incap_seven_priority_ff;
    reg  [2:0]  ext_one_priority_ff;
    reg  [19:0] source_enabled_ff;

    assign prdata                  = prdata_ff;
    assign pready                  = pready_ff;
    assign pslverr                 = pslverr_ff;
    assign timer_one_priority      = timer_one_priority_ff;
    assign outcmp_one_priority     = outcmp_one_priority_ff;
    assign incap_one_priority      = incap_one_priority_ff;
    assign ext_zero_priority       = ext_zero_priority_ff;
    assign timer_two_priority      = timer_two_priority_ff;
    assign outcmp_two_priority     = outcmp_two_priority_ff;
    assign incap_two_priority      = incap_two_priority_ff;
    assign serial_one_rx_priority  = serial_one_rx_priority_ff;
    assign spi_one_event_priority  = spi_one_event_priority_ff;
    assign spi_one_fault_priority  = spi_one_fault_priority_ff;
    assign timer_three_priority    = timer_three_priority_ff;
    assign adc_done_priority       = adc_done_priority_ff;
    assign serial_one_tx_priority  = serial_one_tx_priority_ff;
    assign pin_change_priority     = pin_change_priority_ff;
    assign comparator_priority     = comparator_priority_ff;
    assign twowire_master_priority = twowire_master_priority_ff;
    assign twowire_slave_priority  = twowire_slave_priority_ff;
    assign incap_eight_priority    = incap_eight_priority_ff;
    assign incap_seven_priority    = incap_seven_priority_ff;
    assign ext_one_priority        = ext_one_priority_ff;
    assign source_enabled          = source_enabled_ff;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire        access = psel & penable & pready_ff;
    wire        hit    = (paddr[1:0] == 2'h0) && (paddr[11:2] < `IPC_NUM_REGS);
    wire [2:0]  idx    = paddr[4:2];
    wire [15:0] regv [0:5];

    genvar g;
    generate
        for (g = 0; g < `IPC_NUM_REGS; g = g + 1) begin : g_reg
            localparam [15:0] M = (g == 0) ? `IPC_MASK0 : (g == 1) ? `IPC_MASK1 :
                                  (g == 2) ? `IPC_MASK2 : (g == 3) ? `IPC_MASK3 :
                                  (g == 4) ? `IPC_MASK4 : `IPC_MASK5;
            localparam [15:0] R = (g == 0) ? `IPC_RESET0 : (g == 1) ? `IPC_RESET1 :
                                  (g == 2) ? `IPC_RESET2 : (g == 3) ? `IPC_RESET3 :
                                  (g == 4) ? `IPC_RESET4 : `IPC_RESET5;
            ipc_prio_reg #(.MASK(M), .RESET(R)) u_reg (
                .pclk    (pclk),
                .presetn (presetn),
                .wr_en   (access & pwrite & hit & ({29'h00000000, idx} == g)),
                .wr_data (pwdata[15:0]),
                .value   (regv[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // read data and error answer
    // ----------------------------------------
    // unmapped addresses answer with pslverr and zero data, writes dropped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            // zero wait: ready only in the first access cycle, so one write per transfer
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~hit;
            if (psel & ~penable & ~pwrite & hit)
                prdata_ff <= {16'h0000, regv[idx]}; // RULE6
            else
                prdata_ff <= 32'h00000000;
        end
    end

    // ----------------------------------------
    // field outputs, registered
    // ----------------------------------------
    // fields are handed to the arbiter as the raw code: 111 is level 7, 001 level 1
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_priority_ff      <= `IPC_PRIO_RESET;
            outcmp_one_priority_ff     <= `IPC_PRIO_RESET;
            incap_one_priority_ff      <= `IPC_PRIO_RESET;
            ext_zero_priority_ff       <= `IPC_PRIO_RESET;
            timer_two_priority_ff      <= `IPC_PRIO_RESET;
            outcmp_two_priority_ff     <= `IPC_PRIO_RESET;
            incap_two_priority_ff      <= `IPC_PRIO_RESET;
            serial_one_rx_priority_ff  <= `IPC_PRIO_RESET;
            spi_one_event_priority_ff  <= `IPC_PRIO_RESET;
            spi_one_fault_priority_ff  <= `IPC_PRIO_RESET;
            timer_three_priority_ff    <= `IPC_PRIO_RESET;
            adc_done_priority_ff       <= `IPC_PRIO_RESET;
            serial_one_tx_priority_ff  <= `IPC_PRIO_RESET;
            pin_change_priority_ff     <= `IPC_PRIO_RESET;
            comparator_priority_ff     <= `IPC_PRIO_RESET;
            twowire_master_priority_ff <= `IPC_PRIO_RESET;
            twowire_slave_priority_ff  <= `IPC_PRIO_RESET;
            incap_eight_priority_ff    <= `IPC_PRIO_RESET;
            incap_seven_priority_ff    <= `IPC_PRIO_RESET;
            ext_one_priority_ff        <= `IPC_PRIO_RESET;
        end else begin
            timer_one_priority_ff      <= regv[0][`IPC_FLD_HI_POS +: `IPC_FLD_W]; // RULE1
            outcmp_one_priority_ff     <= regv[0][`IPC_FLD_MH_POS +: `IPC_FLD_W]; // RULE2
            incap_one_priority_ff      <= regv[0][`IPC_FLD_ML_POS +: `IPC_FLD_W];
            ext_zero_priority_ff       <= regv[0][`IPC_FLD_LO_POS +: `IPC_FLD_W];
            timer_two_priority_ff      <= regv[1][`IPC_FLD_HI_POS +: `IPC_FLD_W];
            outcmp_two_priority_ff     <= regv[1][`IPC_FLD_MH_POS +: `IPC_FLD_W];
            incap_two_priority_ff      <= regv[1][`IPC_FLD_ML_POS +: `IPC_FLD_W];
            serial_one_rx_priority_ff  <= regv[2][`IPC_FLD_HI_POS +: `IPC_FLD_W]; // RULE4
            spi_one_event_priority_ff  <= regv[2][`IPC_FLD_MH_POS +: `IPC_FLD_W]; // RULE4
            spi_one_fault_priority_ff  <= regv[2][`IPC_FLD_ML_POS +: `IPC_FLD_W]; // RULE5
            timer_three_priority_ff    <= regv[2][`IPC_FLD_LO_POS +: `IPC_FLD_W]; // RULE5
            adc_done_priority_ff       <= regv[3][`IPC_FLD_ML_POS +: `IPC_FLD_W];
            serial_one_tx_priority_ff  <= regv[3][`IPC_FLD_LO_POS +: `IPC_FLD_W];
            pin_change_priority_ff     <= regv[4][`IPC_FLD_HI_POS +: `IPC_FLD_W];
            comparator_priority_ff     <= regv[4][`IPC_FLD_MH_POS +: `IPC_FLD_W];
            twowire_master_priority_ff <= regv[4][`IPC_FLD_ML_POS +: `IPC_FLD_W];
            twowire_slave_priority_ff  <= regv[4][`IPC_FLD_LO_POS +: `IPC_FLD_W];
            incap_eight_priority_ff    <= regv[5][`IPC_FLD_HI_POS +: `IPC_FLD_W];
            incap_seven_priority_ff    <= regv[5][`IPC_FLD_MH_POS +: `IPC_FLD_W];
            ext_one_priority_ff        <= regv[5][`IPC_FLD_LO_POS +: `IPC_FLD_W];
        end
    end

    // ----------------------------------------
    // per-source enable: zero code masks the source
    // ----------------------------------------
    // the arbiter must gate requests with this, whatever flag and enable show
    wire [59:0] all_codes = {
        regv[5][14:12], regv[5][10:8], regv[5][2:0],
        regv[4][14:12], regv[4][10:8], regv[4][6:4], regv[4][2:0],
        regv[3][6:4],   regv[3][2:0],
        regv[2][14:12], regv[2][10:8], regv[2][6:4], regv[2][2:0],
        regv[1][14:12], regv[1][10:8], regv[1][6:4],
        regv[0][14:12], regv[0][10:8], regv[0][6:4], regv[0][2:0]};

    wire [19:0] nxt_source_enabled;

    genvar e;
    generate
        for (e = 0; e < 20; e = e + 1) begin : g_en
            assign nxt_source_enabled[e] = (all_codes[e*3 +: 3] != `IPC_PRIO_OFF); // RULE3
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            source_enabled_ff <= 20'hFFFFF;
        else
            source_enabled_ff <= nxt_source_enabled;
    end
endmodule

/* ipc_consts.vh */
// constants for the interrupt priority configuration block
// assumes inclusion by bare name from the design files
`ifndef IPC_CONSTS_VH
`define IPC_CONSTS_VH

// ----------------------------------------
// register byte offsets on apb
// ----------------------------------------
`define IPC_OFS_PRIO0 12'h000
`define IPC_OFS_PRIO1 12'h004
`define IPC_OFS_PRIO2 12'h008
`define IPC_OFS_PRIO3 12'h00C
`define IPC_OFS_PRIO4 12'h010
`define IPC_OFS_PRIO5 12'h014
`define IPC_NUM_REGS  6

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define IPC_FLD_W       3
`define IPC_FLD_HI_POS  12
`define IPC_FLD_MH_POS  8
`define IPC_FLD_ML_POS  4
`define IPC_FLD_LO_POS  0
`define IPC_PRIO_RESET  3'h4
`define IPC_PRIO_OFF    3'h0
`define IPC_PRIO_MAX    3'h7
`define IPC_PRIO_MIN    3'h1
// implemented bits per register
`define IPC_MASK0 16'h7777
`define IPC_MASK1 16'h7770
`define IPC_MASK2 16'h7777
`define IPC_MASK3 16'h0077
`define IPC_MASK4 16'h7777
`define IPC_MASK5 16'h7707
`define IPC_RESET0 16'h4444
`define IPC_RESET1 16'h4440
`define IPC_RESET2 16'h4444
`define IPC_RESET3 16'h0044
`define IPC_RESET4 16'h4444
`define IPC_RESET5 16'h4404

`endif

/* ipc_prio_reg.v */
// one 16-bit priority register with fixed implemented-bit mask
// assumes write strobe from the apb decode in the same clock domain
module ipc_prio_reg #(
    parameter [15:0] MASK  = 16'hFFFF,
    parameter [15:0] RESET = 16'h0000
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        wr_en,
    input  wire [15:0] wr_data,
    output wire [15:0] value
);
    reg [15:0] value_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_ff <= RESET; // RULE6
        end else if (wr_en) begin
            value_ff <= wr_data & MASK; // RULE6
        end
    end

    assign value = value_ff;
endmodule

/* ipc_top_props.sv */
// checker: apb and priority output relations of ipc_top
// assumes one pclk domain; bound onto ipc_top below
module ipc_top_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [2:0]  serial_one_rx_priority,
    input wire logic [2:0]  spi_one_event_priority,
    input wire logic [2:0]  spi_one_fault_priority,
    input wire logic [2:0]  timer_three_priority,
    input wire logic [19:0] source_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // field outputs lag the register by one cycle, so two edges after access
    sequence wr2;
        psel && penable && pwrite && paddr == 12'h008;
    endsequence
    a_rx_pos: assert property (wr2 |-> ##2 serial_one_rx_priority == $past(pwdata[14:12], 2))
        else $error("rx field off");
    a_event_pos: assert property (wr2 |-> ##2 spi_one_event_priority == $past(pwdata[10:8], 2))
        else $error("event field off");
    a_fault_pos: assert property (wr2 |-> ##2 spi_one_fault_priority == $past(pwdata[6:4], 2))
        else $error("fault field off");
    a_timer_pos: assert property (wr2 |-> ##2 timer_three_priority == $past(pwdata[2:0], 2))
        else $error("timer field off");
    a_zero_off: assert property (source_enabled[10:7] == {|serial_one_rx_priority, |spi_one_event_priority,
        |spi_one_fault_priority, |timer_three_priority}) else $error("enable mismatch");
    a_reset_four: assert property ($rose(presetn) |-> timer_three_priority == 3'h4 && source_enabled[7])
        else $error("reset code off");
    a_unimpl_zero: assert property (psel && penable && !pwrite && paddr == 12'h008 |-> !(|(prdata & 32'hFFFF8888)))
        else $error("unused bits set");
    a_top_code: assert property (wr2 ##0 pwdata[14:12] == 3'h7 |-> ##2 source_enabled[10])
        else $error("top code off");
endmodule
bind ipc_top ipc_top_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .serial_one_rx_priority, .spi_one_event_priority, .spi_one_fault_priority, .timer_three_priority, .source_enabled);

/* tb.sv */
// bench for ipc_top: apb register traffic and priority outputs
// assumes ipc_top, its header and its checker compiled first
`include "ipc_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, d;
    logic        pready, pslverr, err;
    logic [2:0]  idx, c;
    logic [19:0] src_en;
    wire  [59:0] fld;
    wire  [2:0]  rx = fld[32:30], ev = fld[29:27], flt = fld[26:24], t3 = fld[23:21];
    logic [15:0] mask [0:5] = '{`IPC_MASK0, `IPC_MASK1, `IPC_MASK2, `IPC_MASK3, `IPC_MASK4, `IPC_MASK5};
    logic [15:0] model [0:5] = '{`IPC_RESET0, `IPC_RESET1, `IPC_RESET2, `IPC_RESET3, `IPC_RESET4, `IPC_RESET5};
    int          bad_count = 0, tests_run = 0, seed = 32'h86B3, i;
    always #5 pclk = ~pclk;
    ipc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ext_zero_priority(fld[2:0]), .incap_one_priority(fld[5:3]), .outcmp_one_priority(fld[8:6]),
        .timer_one_priority(fld[11:9]), .incap_two_priority(fld[14:12]), .outcmp_two_priority(fld[17:15]),
        .timer_two_priority(fld[20:18]), .timer_three_priority(fld[23:21]), .spi_one_fault_priority(fld[26:24]),
        .spi_one_event_priority(fld[29:27]), .serial_one_rx_priority(fld[32:30]),
        .serial_one_tx_priority(fld[35:33]), .adc_done_priority(fld[38:36]), .twowire_slave_priority(fld[41:39]),
        .twowire_master_priority(fld[44:42]), .comparator_priority(fld[47:45]), .pin_change_priority(fld[50:48]),
        .ext_one_priority(fld[53:51]), .incap_seven_priority(fld[56:54]), .incap_eight_priority(fld[59:57]),
        .source_enabled(src_en));
    function automatic logic [31:0] exp_rd(input logic [2:0] r, input logic [31:0] v);
        return {16'h0000, v[15:0] & mask[r]};
    endfunction
    // all twenty fields from the register model, lowest source in the low bits
    function automatic logic [59:0] exp_fld();
        return {model[5][14:12], model[5][10:8], model[5][2:0], model[4][14:12], model[4][10:8], model[4][6:4],
            model[4][2:0], model[3][6:4], model[3][2:0], model[2][14:12], model[2][10:8], model[2][6:4],
            model[2][2:0], model[1][14:12], model[1][10:8], model[1][6:4], model[0][14:12], model[0][10:8],
            model[0][6:4], model[0][2:0]};
    endfunction
    function automatic logic [19:0] exp_en(input logic [59:0] f);
        for (int k = 0; k < 20; k++) exp_en[k] = (f[k*3 +: 3] != 3'h0);
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one transfer; read data and error taken at the edge where pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            end_sim();
        end
    endtask
    // write through the bus and keep the register model in step
    task automatic wr(input logic [2:0] r, input logic [31:0] v);
        apb(1'b1, {7'h00, r, 2'h0}, v);
        model[r] = v[15:0] & mask[r];
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, exp_rd(3'(i), 32'h4444));
        end
        chk(32'(src_en), 32'hFFFFF);
        chk(fld, exp_fld());
        $display("reset values done");
        for (i = 0; i < 40; i++) begin
            idx = 3'($unsigned($random(seed)) % 6);
            d = $random(seed);
            wr(idx, d);
            apb(1'b0, {7'h00, idx, 2'h0}, 32'h0);
            chk(rd, exp_rd(idx, d));
            chk(fld, exp_fld());
            chk(src_en, exp_en(exp_fld()));
        end
        $display("random access done");
        // every code in every field of register two, shifted per field
        for (i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(3'h2, {16'h0000, 1'b0, c, 1'b0, c + 3'h1, 1'b0, c + 3'h2, 1'b0, c + 3'h3});
            repeat (2) @(posedge pclk);
            chk({rx, ev}, {c, c + 3'h1});
            chk({flt, t3}, {c + 3'h2, c + 3'h3});
            chk(src_en[10:7], {c != 3'h0, c != 3'h7, c != 3'h6, c != 3'h5});
        end
        $display("code sweep done");
        apb(1'b0, 12'h018, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b0, 12'h002, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h00A, 32'hFFFFFFFF);
        chk(err, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, exp_rd(3'h2, {16'h0000, model[2]}));
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h4444);
        model = '{`IPC_RESET0, `IPC_RESET1, `IPC_RESET2, `IPC_RESET3, `IPC_RESET4, `IPC_RESET5};
        chk(fld, exp_fld());
        chk(32'(src_en), 32'hFFFFF);
        $display("refusal and reset done");
        end_sim();
    end
endmodule
